// file: include/fm_pkg.sv
package fm_pkg;
	// System clock rate
	localparam longint unsigned FM_CLK_HZ = 125_000_000;

	// Modbus register addresses
	localparam logic [15:0] FM_ADDR_FLOW = 16'h0006;
	localparam logic [15:0] FM_ADDR_CONS = 16'h0008;
	localparam logic [15:0] FM_ADDR_REV = 16'h000E;
	localparam logic [15:0] FM_ADDR_DIR = 16'h002A;

	// M-Bus value register addresses
	localparam logic [15:0] FM_MADDR_TOTAL = 16'h0001;
	localparam logic [15:0] FM_MADDR_FLOW = 16'h0002;
	localparam logic [15:0] FM_MADDR_STAT = 16'h0003;

	// M-Bus device addressing and flow direction field
	localparam logic [7:0] FM_MBUS_PRIMARY_RST = 8'h01;
	localparam logic [31:0] FM_DIR_NORMAL = 32'h0000_0000;
	localparam int FM_DIR_BIT = 0;

	// Send order of byte lanes: slot k sends lane FM_TX_ORDER[2k+:2] (1,0,3,2)
	localparam logic [7:0] FM_TX_ORDER = 8'hB1;
	localparam logic [1:0] FM_LAST_SLOT = 2'h3;
	localparam logic [7:0] FM_ERR_BYTE = 8'h00;

	// Times in their own units
	localparam longint unsigned FM_RSP_DELAY_MS = 7;
	localparam longint unsigned FM_RSP_TIMEOUT_MS = 100;
	localparam longint unsigned FM_RX_TIMEOUT_MS = 500;
	localparam longint unsigned FM_RTU_BAUD = 19200;
	localparam longint unsigned FM_RTU_CHAR_BITS = 10;
	localparam longint unsigned FM_RTU_GAP_CHARS = 7;

	// Cycle counts: least times round up, timeouts round down
	localparam int unsigned FM_RSP_DELAY_CYC = int'((FM_RSP_DELAY_MS * FM_CLK_HZ + 999) / 1000);
	localparam int unsigned FM_RSP_TIMEOUT_CYC = int'(FM_RSP_TIMEOUT_MS * FM_CLK_HZ / 1000);
	localparam int unsigned FM_RX_TIMEOUT_CYC = int'(FM_RX_TIMEOUT_MS * FM_CLK_HZ / 1000);
	localparam int unsigned FM_RTU_GAP_CYC = int'((FM_RTU_GAP_CHARS * FM_RTU_CHAR_BITS * FM_CLK_HZ
		+ FM_RTU_BAUD - 1) / FM_RTU_BAUD);

	// Answer sequencer states
	typedef enum logic [1:0] {FM_IDLE, FM_WAIT, FM_SEND} fm_state_t;
endpackage

// file: include/fm_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Start, stop and expiry of one timer
interface fm_tmr_if;
	logic start;
	logic stop;
	logic done;
	modport ctl (output start, output stop, input done);
	modport tmr (input start, input stop, output done);
endinterface
`default_nettype wire

// file: design/fm_tmr.sv
`timescale 1ns/1ps
`default_nettype none
module fm_tmr #(
	parameter int unsigned CYC = 16
) (
	input wire logic sys_clk,
	input wire logic srst_n,
	fm_tmr_if.tmr t
);
	logic run_r;
	logic [31:0] cnt_r;
	logic done_r;
	logic hit;

	assign hit = run_r && (cnt_r == 32'(CYC - 1));
	assign t.done = done_r;

	// Restartable one-shot, done pulses CYC cycles after the start
	always_ff @(posedge sys_clk or negedge srst_n) begin
		if (!srst_n) begin
			run_r <= 1'b0;
			cnt_r <= 32'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= hit && !t.start && !t.stop;
			if (t.start) begin
				run_r <= 1'b1;
				cnt_r <= 32'h0;
			end else if (t.stop || hit) begin
				run_r <= 1'b0;
			end else if (run_r) begin
				cnt_r <= cnt_r + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: design/fm_regmap.sv
`timescale 1ns/1ps
`default_nettype none
module fm_regmap
	import fm_pkg::*;
#(
	parameter int unsigned DELAY_CYC = FM_RSP_DELAY_CYC,
	parameter int unsigned RSP_TO_CYC = FM_RSP_TIMEOUT_CYC,
	parameter int unsigned RX_TO_CYC = FM_RX_TIMEOUT_CYC,
	parameter int unsigned GAP_CYC = FM_RTU_GAP_CYC,
	parameter logic [7:0] MBUS_PRIMARY = FM_MBUS_PRIMARY_RST,
	parameter logic [31:0] MBUS_SERIAL = 32'h1357_2468 // Arbitrary serial, eight BCD digits
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] flow_rate_in,
	input wire logic [31:0] fwd_cons_in,
	input wire logic [31:0] rev_cons_in,
	input wire logic flow_reverse_in,
	input wire logic [31:0] mbus_status_in,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_mbus,
	input wire logic req_tcp,
	input wire logic [7:0] req_conn,
	input wire logic req_write,
	input wire logic [15:0] req_addr,
	input wire logic req_secondary,
	input wire logic [31:0] req_dev_addr,
	input wire logic tcp_close,
	output logic tcp_busy,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [7:0] rsp_byte,
	output logic rsp_last,
	output logic rsp_err,
	output logic rsp_abort,
	input wire logic mbus_rx_byte,
	input wire logic mbus_rx_end,
	output logic mbus_rx_abort,
	input wire logic rtu_rx_byte,
	output logic rtu_frame_gap
);
	logic [1:0] rst_pipe_r;
	logic srst_n;
	logic [31:0] flow_rate_float_r, forward_consumption_total_r, reverse_consumption_total_r;
	logic [31:0] flow_direction_flag_r, mbus_status_word_r;
	fm_state_t st_r, st_nxt;
	logic [1:0] slot_r, slot_nxt;
	logic [31:0] val_r, val_nxt, dec_val;
	logic err_r, err_nxt, dec_hit, hit_dev, drop, foreign, accept;
	logic [7:0] conn_r;
	logic req_ready_r, tcp_busy_r, rsp_valid_r, rsp_last_r, rsp_err_r, rsp_abort_r;
	logic [7:0] rsp_byte_r;
	logic mbus_rx_abort_r, rtu_frame_gap_r;
	logic [31:0] wait_cnt_r;
	fm_tmr_if dly_if ();
	fm_tmr_if rto_if ();
	fm_tmr_if rxt_if ();
	fm_tmr_if gap_if ();

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_r <= 2'h0;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end
	assign srst_n = rst_pipe_r[1];

	// Measurement registers follow the sensor side, never the bus
	always_ff @(posedge sys_clk or negedge srst_n) begin
		if (!srst_n) begin
			flow_rate_float_r <= 32'h0;
			forward_consumption_total_r <= 32'h0;
			reverse_consumption_total_r <= 32'h0;
			flow_direction_flag_r <= FM_DIR_NORMAL;
			mbus_status_word_r <= 32'h0;
		end else begin
			flow_rate_float_r <= flow_rate_in;
			forward_consumption_total_r <= fwd_cons_in;
			reverse_consumption_total_r <= rev_cons_in;
			flow_direction_flag_r <= FM_DIR_NORMAL;
			flow_direction_flag_r[FM_DIR_BIT] <= flow_reverse_in;
			mbus_status_word_r <= mbus_status_in;
		end
	end

	// Address decode for both register maps
	always_comb begin
		dec_hit = 1'b1;
		dec_val = 32'h0;
		if (req_mbus) begin
			case (req_addr)
				FM_MADDR_TOTAL: dec_val = forward_consumption_total_r;
				FM_MADDR_FLOW: dec_val = flow_rate_float_r;
				FM_MADDR_STAT: dec_val = mbus_status_word_r;
				default: dec_hit = 1'b0;
			endcase
		end else begin
			case (req_addr)
				FM_ADDR_FLOW: dec_val = flow_rate_float_r;
				FM_ADDR_CONS: dec_val = forward_consumption_total_r;
				FM_ADDR_REV: dec_val = reverse_consumption_total_r;
				FM_ADDR_DIR: dec_val = flow_direction_flag_r;
				default: dec_hit = 1'b0;
			endcase
		end
	end

	// Request qualification
	assign hit_dev = req_secondary ? (req_dev_addr == MBUS_SERIAL)
		: (req_dev_addr[7:0] == MBUS_PRIMARY);
	assign drop = req_mbus && !hit_dev;
	assign foreign = req_tcp && tcp_busy_r && (req_conn != conn_r);
	assign accept = req_valid && req_ready_r;
	assign val_nxt = accept ? dec_val : val_r;
	assign err_nxt = accept ? (req_write || !dec_hit || foreign) : err_r;

	// Answer sequencer
	always_comb begin
		st_nxt = st_r;
		slot_nxt = slot_r;
		unique case (st_r)
			FM_IDLE: begin
				slot_nxt = 2'h0;
				if (accept && !drop) begin
					st_nxt = req_mbus ? FM_WAIT : FM_SEND;
				end
			end
			FM_WAIT: begin
				if (dly_if.done) begin
					st_nxt = FM_SEND;
				end
			end
			FM_SEND: begin
				if (rto_if.done) begin
					st_nxt = FM_IDLE;
				end else if (rsp_ready && rsp_valid_r) begin
					if (rsp_last_r) begin
						st_nxt = FM_IDLE;
					end else begin
						slot_nxt = slot_r + 2'h1;
					end
				end
			end
		endcase
	end

	// Timer controls
	assign dly_if.start = accept && !drop && req_mbus;
	assign dly_if.stop = 1'b0;
	assign rto_if.start = (st_r == FM_WAIT) && dly_if.done;
	assign rto_if.stop = (st_r == FM_SEND) && (st_nxt == FM_IDLE);
	assign rxt_if.start = mbus_rx_byte;
	assign rxt_if.stop = mbus_rx_end;
	assign gap_if.start = rtu_rx_byte;
	assign gap_if.stop = 1'b0;

	fm_tmr #(.CYC(DELAY_CYC)) u_dly (.sys_clk(sys_clk), .srst_n(srst_n), .t(dly_if));
	fm_tmr #(.CYC(RSP_TO_CYC)) u_rto (.sys_clk(sys_clk), .srst_n(srst_n), .t(rto_if));
	fm_tmr #(.CYC(RX_TO_CYC)) u_rxt (.sys_clk(sys_clk), .srst_n(srst_n), .t(rxt_if));
	fm_tmr #(.CYC(GAP_CYC)) u_gap (.sys_clk(sys_clk), .srst_n(srst_n), .t(gap_if));

	// Sequencer state and answer bytes
	always_ff @(posedge sys_clk or negedge srst_n) begin
		if (!srst_n) begin
			st_r <= FM_IDLE;
			slot_r <= 2'h0;
			val_r <= 32'h0;
			err_r <= 1'b0;
			req_ready_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_byte_r <= 8'h00;
			rsp_last_r <= 1'b0;
			rsp_err_r <= 1'b0;
			rsp_abort_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			slot_r <= slot_nxt;
			val_r <= val_nxt;
			err_r <= err_nxt;
			req_ready_r <= (st_nxt == FM_IDLE);
			rsp_valid_r <= (st_nxt == FM_SEND);
			rsp_byte_r <= err_nxt ? FM_ERR_BYTE : val_nxt[8 * FM_TX_ORDER[2 * slot_nxt +: 2] +: 8];
			rsp_last_r <= err_nxt || (slot_nxt == FM_LAST_SLOT);
			rsp_err_r <= err_nxt;
			rsp_abort_r <= (st_r == FM_SEND) && rto_if.done;
		end
	end

	// TCP connection ownership; an accepted poll that is not foreign wins over a same-cycle close
	always_ff @(posedge sys_clk or negedge srst_n) begin
		if (!srst_n) begin
			tcp_busy_r <= 1'b0;
			conn_r <= 8'h00;
		end else if (accept && req_tcp && !foreign) begin
			tcp_busy_r <= 1'b1;
			conn_r <= req_conn;
		end else if (tcp_close) begin
			tcp_busy_r <= 1'b0;
		end
	end

	// Link frame timeouts
	always_ff @(posedge sys_clk or negedge srst_n) begin
		if (!srst_n) begin
			mbus_rx_abort_r <= 1'b0;
			rtu_frame_gap_r <= 1'b0;
		end else begin
			mbus_rx_abort_r <= rxt_if.done;
			rtu_frame_gap_r <= gap_if.done;
		end
	end

	assign req_ready = req_ready_r;
	assign tcp_busy = tcp_busy_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_byte = rsp_byte_r;
	assign rsp_last = rsp_last_r;
	assign rsp_err = rsp_err_r;
	assign rsp_abort = rsp_abort_r;
	assign mbus_rx_abort = mbus_rx_abort_r;
	assign rtu_frame_gap = rtu_frame_gap_r;

	// Cycles spent waiting before an M-Bus answer
	always_ff @(posedge sys_clk or negedge srst_n) begin
		if (!srst_n) begin
			wait_cnt_r <= 32'h0;
		end else begin
			wait_cnt_r <= (st_r == FM_WAIT) ? wait_cnt_r + 32'h1 : 32'h0;
		end
	end

	default clocking fm_cb @(posedge sys_clk); endclocking
	default disable iff (!srst_n);

	sequence s_mbus_take;
		accept && req_mbus && !drop;
	endsequence
	sequence s_send_end;
		(st_r == FM_SEND) ##1 (st_r == FM_IDLE);
	endsequence

	byte_order_a: assert property (rsp_valid_r && !rsp_err_r |-> rsp_byte_r == (slot_r[1]
		? (slot_r[0] ? val_r[23:16] : val_r[31:24]) : (slot_r[0] ? val_r[7:0] : val_r[15:8])))
		else $error("answer byte out of sequence");
	tcp_single_a: assert property (accept && foreign |=> rsp_err_r && rsp_last_r && tcp_busy_r)
		else $error("second TCP connection served");
	flow_map_a: assert property (accept && !req_mbus && !req_write && req_addr == FM_ADDR_FLOW
		|=> val_r == $past(flow_rate_float_r) && rsp_err_r == $past(foreign))
		else $error("flow register mapped wrong");
	dir_flag_a: assert property (##1 flow_direction_flag_r == {31'h0, $past(flow_reverse_in)})
		else $error("direction flag wrong");
	mbus_addr_a: assert property (accept && drop |=> st_r == FM_IDLE && !rsp_valid_r)
		else $error("foreign M-Bus address answered");
	mbus_delay_a: assert property (s_mbus_take |=> (st_r == FM_WAIT && !rsp_valid_r)[*2]
		or (st_r == FM_WAIT) ##1 (wait_cnt_r == DELAY_CYC && st_nxt == FM_SEND))
		else $error("M-Bus answer delay broken");
	wait_len_a: assert property ((st_r == FM_WAIT) && (st_nxt == FM_SEND) |-> wait_cnt_r == DELAY_CYC)
		else $error("M-Bus answer delay length wrong");
	rsp_abort_a: assert property (rsp_abort_r |-> $past(st_r == FM_SEND) && st_r == FM_IDLE && !rsp_valid_r)
		else $error("reply timeout did not end answer");
	mbus_total_a: assert property (s_mbus_take ##0 (req_addr == FM_MADDR_TOTAL && !req_write)
		|=> val_r == $past(forward_consumption_total_r))
		else $error("M-Bus total mapped wrong");
	rx_quiet_a: assert property (mbus_rx_byte |=> !mbus_rx_abort_r [*2])
		else $error("receive timeout fired early");
	rtu_gap_a: assert property (rtu_rx_byte |=> !rtu_frame_gap_r [*2])
		else $error("frame gap fired early");
	ro_write_a: assert property (accept && req_write && !drop |=> rsp_err_r && rsp_last_r
		##1 flow_rate_float_r == $past(flow_rate_in))
		else $error("write not refused");
	send_done_a: assert property (s_send_end |-> req_ready_r)
		else $error("not ready after answer");
endmodule
`default_nettype wire

// file: sim/fm_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Polling master: takes answer bytes at its own pace and reorders them
module fm_master_model (
	input wire logic sys_clk,
	input wire logic clr,
	input wire logic [1:0] pace,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte,
	input wire logic rsp_last,
	input wire logic rsp_err,
	output logic rsp_ready,
	output logic [31:0] val_msb,
	output logic [31:0] val_lsb,
	output logic [2:0] nbytes,
	output logic got_err,
	output logic got_last
);
	logic [7:0] b [4];
	// Pace 0 prompt, 1 every other cycle, 2 stalls for good
	always_ff @(posedge sys_clk) begin
		rsp_ready <= !clr && (pace == 2'h0 || (pace == 2'h1 && !rsp_ready));
	end
	// Bytes kept in arrival order
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			nbytes <= 3'h0;
			got_err <= 1'b0;
			got_last <= 1'b0;
		end else if (rsp_valid && rsp_ready) begin
			b[nbytes[1:0]] <= rsp_byte;
			nbytes <= nbytes + 3'h1;
			got_err <= rsp_err;
			got_last <= rsp_last;
		end
	end
	// Reordered views for the two host byte orders
	assign val_msb = {b[2], b[3], b[0], b[1]};
	assign val_lsb = {b[1], b[0], b[3], b[2]};
endmodule
`default_nettype wire

// file: sim/tb_fm_regmap.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fm_regmap;
	import fm_pkg::*;
	localparam int DLY = 10;
	localparam int RTO = 40;
	localparam int RXT = 30;
	localparam int GAP = 20;
	localparam logic [31:0] FLOW = 32'h4148_CCCD;
	localparam logic [31:0] FWD = 32'h0001_2345;
	localparam logic [31:0] REV = 32'h0000_0ABC;
	localparam logic [31:0] STAT = 32'h0000_00A5;
	typedef struct packed {logic mb; logic wr; logic [15:0] addr; logic [31:0] exp; logic err; logic [1:0] pc;} fm_row_t;
	fm_row_t rows [9] = '{
		'{1'b0, 1'b0, 16'h0006, FLOW, 1'b0, 2'h0}, '{1'b0, 1'b0, 16'h0008, FWD, 1'b0, 2'h1},
		'{1'b0, 1'b0, 16'h000E, REV, 1'b0, 2'h0}, '{1'b0, 1'b0, 16'h002A, 32'h0, 1'b0, 2'h0},
		'{1'b0, 1'b1, 16'h0008, 32'h0, 1'b1, 2'h0}, '{1'b0, 1'b0, 16'h0007, 32'h0, 1'b1, 2'h0},
		'{1'b1, 1'b0, 16'h0001, FWD, 1'b0, 2'h0}, '{1'b1, 1'b0, 16'h0002, FLOW, 1'b0, 2'h1},
		'{1'b1, 1'b0, 16'h0003, STAT, 1'b0, 2'h0}};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clr = 1'b1;
	logic [1:0] pace = 2'h0;
	logic [59:0] rq = 60'h0;
	logic req_valid = 1'b0, req_mbus, req_tcp, req_write, req_secondary, tcp_close = 1'b0, flow_rev = 1'b0;
	logic [7:0] req_conn;
	logic [15:0] req_addr;
	logic [31:0] req_dev_addr;
	logic mrx_byte = 1'b0, mrx_end = 1'b0, rtu_byte = 1'b0;
	logic req_ready, tcp_busy, rsp_valid, rsp_ready, rsp_last, rsp_err, rsp_abort, mbus_rx_abort, rtu_frame_gap;
	logic [7:0] rsp_byte;
	logic [31:0] val_msb, val_lsb;
	logic [2:0] nbytes;
	logic got_err, got_last;
	int mismatches = 0, checks_done = 0, n_ab = 0, n_rxab = 0, lat;
	assign {req_mbus, req_tcp, req_conn, req_write, req_addr, req_secondary, req_dev_addr} = rq;
	// Clock at 125 MHz
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// Pulse counters for abort outputs
	always @(posedge sys_clk) begin
		if (rsp_abort === 1'b1) n_ab++;
		if (mbus_rx_abort === 1'b1) n_rxab++;
	end
	fm_regmap #(.DELAY_CYC(DLY), .RSP_TO_CYC(RTO), .RX_TO_CYC(RXT), .GAP_CYC(GAP)) i_fm_regmap (
		.sys_clk(sys_clk), .rst_n(rst_n), .flow_rate_in(FLOW), .fwd_cons_in(FWD), .rev_cons_in(REV),
		.flow_reverse_in(flow_rev), .mbus_status_in(STAT), .req_valid(req_valid), .req_ready(req_ready),
		.req_mbus(req_mbus), .req_tcp(req_tcp), .req_conn(req_conn), .req_write(req_write), .req_addr(req_addr),
		.req_secondary(req_secondary), .req_dev_addr(req_dev_addr), .tcp_close(tcp_close), .tcp_busy(tcp_busy),
		.rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
		.rsp_err(rsp_err), .rsp_abort(rsp_abort), .mbus_rx_byte(mrx_byte), .mbus_rx_end(mrx_end),
		.mbus_rx_abort(mbus_rx_abort), .rtu_rx_byte(rtu_byte), .rtu_frame_gap(rtu_frame_gap));
	fm_master_model i_fm_master_model (.sys_clk(sys_clk), .clr(clr), .pace(pace), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .rsp_last(rsp_last), .rsp_err(rsp_err), .rsp_ready(rsp_ready), .val_msb(val_msb),
		.val_lsb(val_lsb), .nbytes(nbytes), .got_err(got_err), .got_last(got_last));
	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One request held until taken, then latency to first byte and wait for the end
	task automatic req(input logic [1:0] pc, input logic mb, input logic tc, input logic [7:0] cn,
		input logic wr, input logic [15:0] ad, input logic sc, input logic [31:0] dv);
		int n;
		@(posedge sys_clk);
		pace <= pc;
		clr <= 1'b1;
		req_valid <= 1'b1;
		rq <= {mb, tc, cn, wr, ad, sc, dv};
		n = 0;
		do begin
			@(posedge sys_clk);
			clr <= 1'b0;
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		if (req_ready !== 1'b1) check("take timeout", req_ready, 1'b1);
		req_valid <= 1'b0;
		lat = 0;
		do begin
			@(posedge sys_clk);
			#1;
			lat++;
		end while (rsp_valid !== 1'b1 && lat < 60);
		n = 0;
		while (req_ready !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (req_ready !== 1'b1) check("end timeout", req_ready, 1'b1);
	endtask
	// Answer bytes against the expected value
	task automatic result(input logic [31:0] exp, input logic err);
		check("bytes", nbytes, err ? 1 : 4);
		check("error", got_err, err);
		check("last", got_last, 1'b1);
		if (err) check("err byte", val_msb[15:8], 8'h00);
		else begin
			check("value", val_msb, exp);
			check("value lsb", val_lsb, {exp[7:0], exp[15:8], exp[23:16], exp[31:24]});
		end
	endtask
	// Event pulse, then cycles until the timer output
	task automatic timed(input logic rtu, output int n);
		@(posedge sys_clk);
		if (rtu) rtu_byte <= 1'b1;
		else mrx_byte <= 1'b1;
		@(posedge sys_clk);
		rtu_byte <= 1'b0;
		mrx_byte <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while ((rtu ? rtu_frame_gap : mbus_rx_abort) !== 1'b1 && n < 100);
	endtask
	// Watchdog
	initial begin
		#(8 * 20000);
		mismatches++;
		close_out();
	end
	// Main sequence
	initial begin
		repeat (7) @(posedge sys_clk);
		#1;
		check("ready in reset", req_ready, 1'b0);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			req(rows[i].pc, rows[i].mb, 1'b0, 8'h00, rows[i].wr, rows[i].addr, 1'b0, 32'h1);
			check("latency", lat, rows[i].mb ? DLY + 1 : 1);
			result(rows[i].exp, rows[i].err);
		end
		@(posedge sys_clk);
		flow_rev <= 1'b1;
		req(2'h0, 1'b0, 1'b0, 8'h00, 1'b0, 16'h002A, 1'b0, 32'h0);
		result(32'h1, 1'b0);
		req(2'h0, 1'b1, 1'b0, 8'h00, 1'b0, 16'h0003, 1'b1, 32'h1357_2468);
		result(STAT, 1'b0);
		req(2'h0, 1'b1, 1'b0, 8'h00, 1'b0, 16'h0003, 1'b1, 32'h1357_2469);
		check("silent sec", nbytes, 3'h0);
		check("silent lat", lat, 60);
		req(2'h0, 1'b1, 1'b0, 8'h00, 1'b0, 16'h0003, 1'b0, 32'h2);
		check("silent pri", nbytes, 3'h0);
		req(2'h0, 1'b0, 1'b1, 8'h05, 1'b0, 16'h0006, 1'b0, 32'h0);
		check("busy", tcp_busy, 1'b1);
		req(2'h0, 1'b0, 1'b1, 8'h06, 1'b0, 16'h0006, 1'b0, 32'h0);
		result(32'h0, 1'b1);
		@(posedge sys_clk);
		tcp_close <= 1'b1;
		@(posedge sys_clk);
		tcp_close <= 1'b0;
		#1;
		check("released", tcp_busy, 1'b0);
		req(2'h0, 1'b0, 1'b1, 8'h06, 1'b0, 16'h0006, 1'b0, 32'h0);
		result(FLOW, 1'b0);
		req(2'h2, 1'b1, 1'b0, 8'h00, 1'b0, 16'h0001, 1'b0, 32'h1);
		@(posedge sys_clk);
		#1;
		check("abort", n_ab, 1);
		check("abort bytes", nbytes, 3'h0);
		timed(1'b0, lat);
		check("rx timeout", lat, RXT + 1);
		timed(1'b1, lat);
		check("frame gap", lat, GAP + 1);
		@(posedge sys_clk);
		mrx_byte <= 1'b1;
		@(posedge sys_clk);
		mrx_byte <= 1'b0;
		mrx_end <= 1'b1;
		@(posedge sys_clk);
		mrx_end <= 1'b0;
		repeat (RXT + 10) @(posedge sys_clk);
		check("rx done", n_rxab, 1);
		close_out();
	end
endmodule
`default_nettype wire
